// ==== trace_driver_emphasis_cfg_regs.sv ====
// Trace driver emphasis and swing configuration register bank with APB access.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "trace_emph_defs.svh"
module trace_driver_emphasis_cfg_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`TDE_APB_AW-1:0] i_paddr,
  input wire logic [`TDE_APB_DW-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [`TDE_APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_serial_out_zero_rate_hd,
  input wire logic i_serial_out_one_rate_3g,
  output logic [4:0] o_hd_out0_emph_pulse_width,
  output logic o_hd_out0_emph_off,
  output logic [5:0] o_hd_out0_emph_level,
  output logic [5:0] o_hd_out0_swing_level,
  output logic o_hd_out0_set_active,
  output logic [4:0] o_rate3g_out1_emph_pulse_width,
  output logic o_rate3g_out1_emph_off,
  output logic [5:0] o_rate3g_out1_emph_level,
  output logic [5:0] o_rate3g_out1_swing_level,
  output logic o_rate3g_out1_set_active
);

  trace_emph_access_if acc ();

  trace_emph_apb_front u_front (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .acc(acc.front)
  );

  trace_emph_pkg::cfg_word_t hd_emph_reg;
  trace_emph_pkg::cfg_word_t hd_emph_next;
  trace_emph_pkg::cfg_word_t hd_swing_reg;
  trace_emph_pkg::cfg_word_t hd_swing_next;
  trace_emph_pkg::cfg_word_t rate3g_emph_reg;
  trace_emph_pkg::cfg_word_t rate3g_emph_next;
  trace_emph_pkg::cfg_word_t rate3g_swing_reg;
  trace_emph_pkg::cfg_word_t rate3g_swing_next;
  logic hd_active_reg;
  logic rate3g_active_reg;
  logic hd_emph_we;
  logic hd_swing_we;
  logic rate3g_emph_we;
  logic rate3g_swing_we;
  trace_emph_pkg::cfg_word_t rd_word;

  assign hd_emph_we = acc.wr_en & (acc.sel == trace_emph_pkg::sel_hd_emph);
  assign hd_swing_we = acc.wr_en & (acc.sel == trace_emph_pkg::sel_hd_swing);
  assign rate3g_emph_we = acc.wr_en & (acc.sel == trace_emph_pkg::sel_3g_emph);
  assign rate3g_swing_we = acc.wr_en & (acc.sel == trace_emph_pkg::sel_3g_swing);

  // Reserved bits are stored as written; software is expected to write back what it read.
  assign hd_emph_next = hd_emph_we ?
    trace_emph_pkg::merge_word(hd_emph_reg, acc.wr_data, acc.wr_mask) : hd_emph_reg;
  assign hd_swing_next = hd_swing_we ?
    trace_emph_pkg::merge_word(hd_swing_reg, acc.wr_data, acc.wr_mask) : hd_swing_reg;
  assign rate3g_emph_next = rate3g_emph_we ?
    trace_emph_pkg::merge_word(rate3g_emph_reg, acc.wr_data, acc.wr_mask) : rate3g_emph_reg;
  assign rate3g_swing_next = rate3g_swing_we ?
    trace_emph_pkg::merge_word(rate3g_swing_reg, acc.wr_data, acc.wr_mask) : rate3g_swing_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hd_emph_reg <= `TDE_EMPH_RST;
      hd_swing_reg <= `TDE_SWING_RST;
      rate3g_emph_reg <= `TDE_EMPH_RST;
      rate3g_swing_reg <= `TDE_SWING_RST;
    end else begin
      hd_emph_reg <= hd_emph_next;
      hd_swing_reg <= hd_swing_next;
      rate3g_emph_reg <= rate3g_emph_next;
      rate3g_swing_reg <= rate3g_swing_next;
    end
  end

  // The rate indications come from logic on this clock, so one register stage suffices.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hd_active_reg <= 1'b0;
      rate3g_active_reg <= 1'b0;
    end else begin
      hd_active_reg <= i_serial_out_zero_rate_hd;
      rate3g_active_reg <= i_serial_out_one_rate_3g;
    end
  end

  assign rd_word = (acc.sel == trace_emph_pkg::sel_hd_emph) ? hd_emph_reg :
                   (acc.sel == trace_emph_pkg::sel_hd_swing) ? hd_swing_reg :
                   (acc.sel == trace_emph_pkg::sel_3g_emph) ? rate3g_emph_reg :
                   (acc.sel == trace_emph_pkg::sel_3g_swing) ? rate3g_swing_reg : 16'h0000;
  assign acc.rd_data = rd_word;

  assign o_hd_out0_emph_pulse_width = hd_emph_reg[`TDE_WIDTH_MSB:`TDE_WIDTH_LSB];
  assign o_hd_out0_emph_off = hd_emph_reg[`TDE_OFF_BIT];
  assign o_hd_out0_emph_level = hd_emph_reg[`TDE_LEVEL_MSB:`TDE_LEVEL_LSB];
  assign o_hd_out0_swing_level = hd_swing_reg[`TDE_SWING_MSB:`TDE_SWING_LSB];
  assign o_hd_out0_set_active = hd_active_reg;
  assign o_rate3g_out1_emph_pulse_width = rate3g_emph_reg[`TDE_WIDTH_MSB:`TDE_WIDTH_LSB];
  assign o_rate3g_out1_emph_off = rate3g_emph_reg[`TDE_OFF_BIT];
  assign o_rate3g_out1_emph_level = rate3g_emph_reg[`TDE_LEVEL_MSB:`TDE_LEVEL_LSB];
  assign o_rate3g_out1_swing_level = rate3g_swing_reg[`TDE_SWING_MSB:`TDE_SWING_LSB];
  assign o_rate3g_out1_set_active = rate3g_active_reg;

  // Checks below watch the bus ports, the rate inputs and the control outputs that they steer.
  default clocking cb @(posedge i_ref_clk);
  endclocking

  default disable iff (!i_rst_n);

  logic apb_wr_full;
  logic apb_access;
  assign apb_access = i_psel & i_penable;
  assign apb_wr_full = apb_access & i_pwrite & (i_pstrb[1:0] == 2'b11);

  a_hd_width_reset: assert property (
    $rose(i_rst_n) |-> (o_hd_out0_emph_pulse_width == 5'h02)
  ) else $error("HD pulse width did not reset to 2.");

  a_hd_width_write: assert property (
    apb_wr_full && (i_paddr == `TDE_ADDR_HD_EMPH)
    |=> (o_hd_out0_emph_pulse_width == $past(i_pwdata[12:8]))
  ) else $error("HD pulse width did not take the written value.");

  a_hd_off_write: assert property (
    apb_access && i_pwrite && i_pstrb[0] && (i_paddr == `TDE_ADDR_HD_EMPH)
    |=> (o_hd_out0_emph_off == $past(i_pwdata[6]))
  ) else $error("HD emphasis power-down bit did not follow the write.");

  a_hd_off_stable: assert property (
    !(apb_access && i_pwrite && (i_paddr == `TDE_ADDR_HD_EMPH)) |=> $stable(o_hd_out0_emph_off)
  ) else $error("HD emphasis power-down bit changed without a write.");

  a_hd_level_write: assert property (
    apb_wr_full && (i_paddr == `TDE_ADDR_HD_EMPH)
    |=> (o_hd_out0_emph_level == $past(i_pwdata[5:0])) ##1 $stable(o_hd_out0_emph_level)
  ) else $error("HD emphasis amplitude did not take the written value.");

  a_hd_swing_write: assert property (
    apb_wr_full && (i_paddr == `TDE_ADDR_HD_SWING)
    |=> (o_hd_out0_swing_level == $past(i_pwdata[13:8]))
  ) else $error("HD swing did not take the written value.");

  a_reserved_reset: assert property (
    $rose(i_rst_n) |-> (hd_swing_reg == `TDE_SWING_RST) && (rate3g_swing_reg == `TDE_SWING_RST)
    && (hd_emph_reg == `TDE_EMPH_RST) && (rate3g_emph_reg == `TDE_EMPH_RST)
  ) else $error("Register words did not come out of reset with their listed values.");

  a_reserved_lane_hold: assert property (
    apb_access && i_pwrite && !i_pstrb[0] && (i_paddr == `TDE_ADDR_HD_SWING)
    |=> (hd_swing_reg[7:0] == $past(hd_swing_reg[7:0]))
  ) else $error("Unstrobed low byte of the HD swing word changed.");

  a_3g_width_write: assert property (
    apb_wr_full && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (o_rate3g_out1_emph_pulse_width == $past(i_pwdata[12:8]))
  ) else $error("3G pulse width did not take the written value.");

  a_3g_off_reset: assert property (
    $rose(i_rst_n) |-> !o_rate3g_out1_emph_off && (o_rate3g_out1_emph_level == 6'h01)
  ) else $error("3G emphasis did not reset powered up with amplitude 1.");

  a_3g_off_write: assert property (
    apb_access && i_pwrite && i_pstrb[0] && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (o_rate3g_out1_emph_off == $past(i_pwdata[6]))
  ) else $error("3G emphasis power-down bit did not follow the write.");

  a_3g_level_write: assert property (
    apb_wr_full && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (o_rate3g_out1_emph_level == $past(i_pwdata[5:0]))
  ) else $error("3G emphasis amplitude did not take the written value.");

  a_3g_swing_reset: assert property (
    $rose(i_rst_n) |-> (o_rate3g_out1_swing_level == 6'h11) && (o_hd_out0_swing_level == 6'h11)
  ) else $error("Swing settings did not reset to 11h.");

  a_3g_swing_write: assert property (
    apb_wr_full && (i_paddr == `TDE_ADDR_3G_SWING)
    |=> (o_rate3g_out1_swing_level == $past(i_pwdata[13:8]))
  ) else $error("3G swing did not take the written value.");

  a_rate_apply: assert property (
    i_rst_n && (i_serial_out_zero_rate_hd && !i_serial_out_one_rate_3g)
    |=> o_hd_out0_set_active && !o_rate3g_out1_set_active
  ) else $error("Applied field sets do not follow the selected rate.");

  a_rate_drop: assert property (
    $fell(i_serial_out_one_rate_3g) |=> $fell(o_rate3g_out1_set_active)
  ) else $error("3G field set stayed applied after the rate changed.");

  a_read_back: assert property (
    i_psel && !i_penable && !i_pwrite && (i_paddr == `TDE_ADDR_HD_SWING)
    |=> (o_prdata == {16'h0000, $past(hd_swing_reg)})
  ) else $error("Read of the HD swing word returned wrong data.");

  a_unmapped_err: assert property (
    apb_access && (trace_emph_pkg::decode_sel(i_paddr) == trace_emph_pkg::sel_none)
    |-> o_pslverr ##1 ($stable(hd_emph_reg) && $stable(rate3g_swing_reg))
  ) else $error("Unmapped access did not error or it altered a register.");

  a_hd_emph_hold: assert property (
    !(apb_access && i_pwrite && (i_paddr == `TDE_ADDR_HD_EMPH)) |=> $stable(hd_emph_reg)
  ) else $error("HD emphasis word changed without a write.");

  a_hd_swing_hold: assert property (
    !(apb_access && i_pwrite && (i_paddr == `TDE_ADDR_HD_SWING)) |=> $stable(hd_swing_reg)
  ) else $error("HD swing word changed without a write.");

  a_3g_emph_hold: assert property (
    !(apb_access && i_pwrite && (i_paddr == `TDE_ADDR_3G_EMPH)) |=> $stable(rate3g_emph_reg)
  ) else $error("3G emphasis word changed without a write.");

  a_3g_swing_hold: assert property (
    !(apb_access && i_pwrite && (i_paddr == `TDE_ADDR_3G_SWING)) |=> $stable(rate3g_swing_reg)
  ) else $error("3G swing word changed without a write.");

  a_hd_level_reset: assert property (
    $rose(i_rst_n) |-> (o_hd_out0_emph_level == `TDE_LEVEL_RST) && !o_hd_out0_emph_off
  ) else $error("HD emphasis did not reset powered up with amplitude 1.");

  a_3g_width_reset: assert property (
    $rose(i_rst_n) |-> (o_rate3g_out1_emph_pulse_width == `TDE_WIDTH_RST)
  ) else $error("3G pulse width did not reset to 2.");

  a_3g_level_lane: assert property (
    apb_access && i_pwrite && i_pstrb[0] && !i_pstrb[1] && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (o_rate3g_out1_emph_level == $past(i_pwdata[5:0]))
    && (o_rate3g_out1_emph_pulse_width == $past(o_rate3g_out1_emph_pulse_width))
  ) else $error("Low-lane write to the 3G emphasis word left its lane.");

  a_3g_width_lane: assert property (
    apb_access && i_pwrite && i_pstrb[1] && !i_pstrb[0] && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (o_rate3g_out1_emph_pulse_width == $past(i_pwdata[12:8]))
    && (o_rate3g_out1_emph_level == $past(o_rate3g_out1_emph_level))
  ) else $error("High-lane write to the 3G emphasis word left its lane.");

  a_3g_low_hold: assert property (
    apb_access && i_pwrite && !i_pstrb[0] && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (rate3g_emph_reg[7:0] == $past(rate3g_emph_reg[7:0]))
  ) else $error("Unstrobed low byte of the 3G emphasis word changed.");

  a_3g_high_hold: assert property (
    apb_access && i_pwrite && !i_pstrb[1] && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (rate3g_emph_reg[15:8] == $past(rate3g_emph_reg[15:8]))
  ) else $error("Unstrobed high byte of the 3G emphasis word changed.");

  a_hd_swing_lane: assert property (
    apb_access && i_pwrite && i_pstrb[1] && (i_paddr == `TDE_ADDR_HD_SWING)
    |=> (o_hd_out0_swing_level == $past(i_pwdata[13:8]))
  ) else $error("High-lane write did not set the HD swing.");

  a_slverr_idle: assert property (
    !apb_access |-> !o_pslverr
  ) else $error("Slave error raised outside an access phase.");

  a_slverr_mapped: assert property (
    apb_access && ((i_paddr == `TDE_ADDR_HD_EMPH) || (i_paddr == `TDE_ADDR_HD_SWING)
    || (i_paddr == `TDE_ADDR_3G_EMPH) || (i_paddr == `TDE_ADDR_3G_SWING)) |-> !o_pslverr
  ) else $error("Slave error raised for a mapped register.");

  a_read_hd_emph: assert property (
    i_psel && !i_penable && !i_pwrite && (i_paddr == `TDE_ADDR_HD_EMPH)
    |=> (o_prdata == {16'h0000, $past(hd_emph_reg)})
  ) else $error("Read of the HD emphasis word returned wrong data.");

  a_read_3g_emph: assert property (
    i_psel && !i_penable && !i_pwrite && (i_paddr == `TDE_ADDR_3G_EMPH)
    |=> (o_prdata == {16'h0000, $past(rate3g_emph_reg)})
  ) else $error("Read of the 3G emphasis word returned wrong data.");

  a_read_3g_swing: assert property (
    i_psel && !i_penable && !i_pwrite && (i_paddr == `TDE_ADDR_3G_SWING)
    |=> (o_prdata == {16'h0000, $past(rate3g_swing_reg)})
  ) else $error("Read of the 3G swing word returned wrong data.");

  a_read_unmapped: assert property (
    i_psel && !i_penable && !i_pwrite && (trace_emph_pkg::decode_sel(i_paddr) == trace_emph_pkg::sel_none)
    |=> (o_prdata == 32'h0000_0000)
  ) else $error("Read of an unmapped address returned nonzero data.");

  a_rate_hd_drop: assert property (
    i_rst_n && !i_serial_out_zero_rate_hd |=> !o_hd_out0_set_active
  ) else $error("HD field set stayed applied after the rate changed.");

  a_rate_3g_apply: assert property (
    i_rst_n && i_serial_out_one_rate_3g |=> o_rate3g_out1_set_active
  ) else $error("3G field set was not applied for the selected rate.");

endmodule : trace_driver_emphasis_cfg_regs
`default_nettype wire

// ==== trace_emph_defs.svh ====
// Constants for the trace driver emphasis configuration register bank.
// Summary of operation
// - HD out0 pulse width bits 12:8, reset 2.
// - HD out0 bit 6 powers emphasis down.
// - HD out0 amplitude bits 5:0, reset 1.
// - HD out0 swing bits 13:8, reset 11h.
// - Reserved fields reset as listed, stored as written.
// - 3G out1 pulse width bits 12:8, reset 2.
// - 3G out1 bit 6 powers emphasis down.
// - 3G out1 amplitude bits 5:0, reset 1.
// - 3G out1 swing bits 13:8, reset 11h.
`ifndef TRACE_EMPH_DEFS_SVH
`define TRACE_EMPH_DEFS_SVH

`define TDE_APB_AW 12
`define TDE_APB_DW 32
`define TDE_WORD_W 16

`define TDE_IDX_HD_EMPH 10'h02e
`define TDE_IDX_HD_SWING 10'h02f
`define TDE_IDX_3G_EMPH 10'h030
`define TDE_IDX_3G_SWING 10'h031

`define TDE_ADDR_HD_EMPH {`TDE_IDX_HD_EMPH, 2'b00}
`define TDE_ADDR_HD_SWING {`TDE_IDX_HD_SWING, 2'b00}
`define TDE_ADDR_3G_EMPH {`TDE_IDX_3G_EMPH, 2'b00}
`define TDE_ADDR_3G_SWING {`TDE_IDX_3G_SWING, 2'b00}

`define TDE_WIDTH_MSB 12
`define TDE_WIDTH_LSB 8
`define TDE_OFF_BIT 6
`define TDE_LEVEL_MSB 5
`define TDE_LEVEL_LSB 0
`define TDE_SWING_MSB 13
`define TDE_SWING_LSB 8

`define TDE_EMPH_RST 16'h0201
`define TDE_SWING_RST 16'h1170
`define TDE_WIDTH_RST 5'h02
`define TDE_LEVEL_RST 6'h01
`define TDE_SWING_LVL_RST 6'h11
`define TDE_SWING_LOW_RST 8'h70

`endif

// ==== trace_emph_pkg.sv ====
// Types and helper functions for the trace driver emphasis configuration bank.
`include "trace_emph_defs.svh"
package trace_emph_pkg;

  typedef logic [`TDE_WORD_W-1:0] cfg_word_t;

  typedef enum logic [4:0] {
    sel_none = 5'b00001,
    sel_hd_emph = 5'b00010,
    sel_hd_swing = 5'b00100,
    sel_3g_emph = 5'b01000,
    sel_3g_swing = 5'b10000
  } reg_sel_t;

  function automatic reg_sel_t decode_sel(input logic [`TDE_APB_AW-1:0] addr);
    reg_sel_t sel;
    sel = sel_none;
    if (addr[1:0] == 2'b00) begin
      case (addr[`TDE_APB_AW-1:2])
        `TDE_IDX_HD_EMPH: sel = sel_hd_emph;
        `TDE_IDX_HD_SWING: sel = sel_hd_swing;
        `TDE_IDX_3G_EMPH: sel = sel_3g_emph;
        `TDE_IDX_3G_SWING: sel = sel_3g_swing;
        default: sel = sel_none;
      endcase
    end
    return sel;
  endfunction : decode_sel

  function automatic cfg_word_t merge_word(input cfg_word_t old_word, input cfg_word_t new_word,
                                           input cfg_word_t mask);
    return (old_word & ~mask) | (new_word & mask);
  endfunction : merge_word

endpackage : trace_emph_pkg

// ==== trace_emph_access_if.sv ====
// Register access carrier between the bus front end and the register bank.
`timescale 1ns/100ps
`default_nettype none
interface trace_emph_access_if;
  trace_emph_pkg::reg_sel_t sel;
  logic wr_en;
  trace_emph_pkg::cfg_word_t wr_data;
  trace_emph_pkg::cfg_word_t wr_mask;
  trace_emph_pkg::cfg_word_t rd_data;

  modport front (
    output sel,
    output wr_en,
    output wr_data,
    output wr_mask,
    input rd_data
  );

  modport bank (
    input sel,
    input wr_en,
    input wr_data,
    input wr_mask,
    output rd_data
  );
endinterface : trace_emph_access_if
`default_nettype wire

// ==== trace_emph_apb_front.sv ====
// APB slave front end that decodes accesses for the emphasis register bank.
`timescale 1ns/100ps
`default_nettype none
`include "trace_emph_defs.svh"
module trace_emph_apb_front (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`TDE_APB_AW-1:0] i_paddr,
  input wire logic [`TDE_APB_DW-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [`TDE_APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  trace_emph_access_if.front acc
);

  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  logic [`TDE_APB_DW-1:0] prdata_reg;
  logic [`TDE_APB_DW-1:0] prdata_next;

  assign setup_phase = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  assign acc.sel = trace_emph_pkg::decode_sel(i_paddr);
  assign addr_hit = (acc.sel != trace_emph_pkg::sel_none);
  // Byte lanes above the 16-bit word have no storage, so their strobes are ignored.
  assign acc.wr_mask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  assign acc.wr_data = i_pwdata[`TDE_WORD_W-1:0];
  assign acc.wr_en = access_phase & i_pwrite & addr_hit;

  // Read data is captured in the setup cycle so that it leaves a flip-flop in the access cycle.
  assign prdata_next = (setup_phase & ~i_pwrite) ? {16'h0000, acc.rd_data} : prdata_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase & ~addr_hit;

endmodule : trace_emph_apb_front
`default_nettype wire

// ==== trace_driver_emphasis_cfg_regs_test.sv ====
// Self-checking testbench for the trace driver emphasis configuration register bank.
`timescale 1ns/100ps
`default_nettype none
`include "trace_emph_defs.svh"
module trace_driver_emphasis_cfg_regs_test;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [`TDE_APB_AW-1:0] paddr = 12'h000;
  logic [`TDE_APB_DW-1:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic rate_hd = 1'h0;
  logic rate_3g = 1'h0;
  logic [`TDE_APB_DW-1:0] prdata;
  logic pready, pslverr, act_hd, act_3g, off_hd, off_3g;
  logic [4:0] wid_hd, wid_3g;
  logic [5:0] lvl_hd, lvl_3g, swg_hd, swg_3g;
  trace_emph_pkg::cfg_word_t mdl [4];
  logic [`TDE_APB_AW-1:0] addr_of [4];
  logic [33:0] exp_q [$];
  logic [33:0] note;
  int errors = 0;
  int checks_done = 0;

  trace_driver_emphasis_cfg_regs u_dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_serial_out_zero_rate_hd(rate_hd), .i_serial_out_one_rate_3g(rate_3g),
    .o_hd_out0_emph_pulse_width(wid_hd), .o_hd_out0_emph_off(off_hd), .o_hd_out0_emph_level(lvl_hd),
    .o_hd_out0_swing_level(swg_hd), .o_hd_out0_set_active(act_hd),
    .o_rate3g_out1_emph_pulse_width(wid_3g), .o_rate3g_out1_emph_off(off_3g),
    .o_rate3g_out1_emph_level(lvl_3g), .o_rate3g_out1_swing_level(swg_3g), .o_rate3g_out1_set_active(act_3g)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // The model follows the byte strobes, so a lane that must be ignored shows up as a mismatch.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    int i;
    logic hit;
    hit = (a[1:0] == 2'h0) && (a >= `TDE_ADDR_HD_EMPH) && (a <= `TDE_ADDR_3G_SWING);
    i = hit ? (int'(a) - int'(`TDE_ADDR_HD_EMPH)) / 4 : 0;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {~d, d};
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'h1;
    exp_q.push_back({wr, !hit, hit ? {16'h0000, mdl[i]} : 32'h0});
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 100);
    if (n >= 100) begin
      errors++;
    end
    if (wr && hit && s[0]) mdl[i][7:0] = d[7:0];
    if (wr && hit && s[1]) mdl[i][15:8] = d[15:8];
    penable <= 1'h0;
  endtask : apb

  task automatic bus_idle();
    psel <= 1'h0;
    @(posedge ref_clk);
  endtask : bus_idle

  task automatic read_all();
    for (int i = 0; i < 4; i++) apb(1'h0, addr_of[i], 16'h0000, 4'h0);
    bus_idle();
  endtask : read_all

  task automatic chk_fields();
    @(negedge ref_clk);
    check("hd_width", wid_hd, mdl[0][12:8]);
    check("hd_off", off_hd, mdl[0][6]);
    check("hd_level", lvl_hd, mdl[0][5:0]);
    check("hd_swing", swg_hd, mdl[1][13:8]);
    check("g3_width", wid_3g, mdl[2][12:8]);
    check("g3_off", off_3g, mdl[2][6]);
    check("g3_level", lvl_3g, mdl[2][5:0]);
    check("g3_swing", swg_3g, mdl[3][13:8]);
    @(posedge ref_clk);
  endtask : chk_fields

  always @(posedge ref_clk) begin
    if (rst_n && psel && penable && pready === 1'h1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("pslverr", pslverr, note[32]);
      if (!note[33]) check("prdata", prdata, note[31:0]);
    end
  end

  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    int k;
    logic [4:0] wd;
    logic [5:0] lv, sw;
    logic of, rh, r3;
    addr_of = '{`TDE_ADDR_HD_EMPH, `TDE_ADDR_HD_SWING, `TDE_ADDR_3G_EMPH, `TDE_ADDR_3G_SWING};
    mdl = '{`TDE_EMPH_RST, `TDE_SWING_RST, `TDE_EMPH_RST, `TDE_SWING_RST};
    k = $urandom(28461);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    chk_fields();
    read_all();
    $display("test reset values done");
    // Zero, full scale, then random codes; all stay in range and keep reserved bits at reset.
    for (k = 0; k < 6; k++) begin
      for (int j = 0; j < 4; j += 2) begin
        wd = (k == 0) ? 5'h00 : (k == 1) ? 5'h0f : 5'($urandom_range(15, 0));
        lv = (k == 0) ? 6'h00 : (k == 1) ? 6'h32 : 6'($urandom_range(50, 0));
        sw = (k == 0) ? 6'h00 : (k == 1) ? 6'h28 : 6'($urandom_range(40, 0));
        of = (k == 1) ? 1'h1 : 1'($urandom);
        apb(1'h1, addr_of[j], {3'h0, wd, 1'h0, of, lv}, 4'h3);
        apb(1'h1, addr_of[j + 1], {2'h0, sw, 8'h70}, 4'h3);
      end
      bus_idle();
      chk_fields();
      read_all();
    end
    $display("test field writes done");
    for (k = 0; k < 4; k++) begin
      apb(1'h1, addr_of[2], {3'h0, 5'(k + 3), 2'h0, 6'(k * 7 + 5)}, (k == 0) ? 4'h1 : (k == 1) ? 4'h2 : 4'hc);
      apb(1'h1, addr_of[1], {2'h0, 6'(k + 9), 8'h70}, (k == 3) ? 4'h0 : 4'h2);
    end
    bus_idle();
    chk_fields();
    read_all();
    $display("test byte strobes done");
    for (k = 0; k < 4; k++) begin
      apb(1'h1, (k == 0) ? 12'hb4 : (k == 1) ? 12'hc8 : (k == 2) ? 12'hb9 : 12'hc2, 16'h0000, 4'h3);
      apb(1'h0, (k == 0) ? 12'hb4 : (k == 1) ? 12'hc8 : (k == 2) ? 12'hbd : 12'hc2, 16'h0000, 4'h0);
    end
    bus_idle();
    chk_fields();
    $display("test unmapped access done");
    for (k = 0; k < 16; k++) begin
      rh = 1'($urandom);
      r3 = 1'($urandom);
      rate_hd <= rh;
      rate_3g <= r3;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("hd_active", act_hd, rh);
      check("g3_active", act_3g, r3);
      @(posedge ref_clk);
    end
    $display("test rate select done");
    rst_n <= 1'h0;
    mdl = '{`TDE_EMPH_RST, `TDE_SWING_RST, `TDE_EMPH_RST, `TDE_SWING_RST};
    chk_fields();
    @(negedge ref_clk);
    check("hd_active_rst", act_hd, 1'h0);
    check("g3_active_rst", act_3g, 1'h0);
    @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    read_all();
    $display("test mid-run reset done");
    close_out();
  end
endmodule : trace_driver_emphasis_cfg_regs_test
`default_nettype wire
